/* File: reset_source_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_source_controller_tb;

	localparam logic [15:0] VEC = 16'hc3a5;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp, rst_pin_n, wdog_reset, fetch_valid;
	logic sys_reset, cpu_start, trap_irq, irq_active, wdog_enable;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] fetch_addr, start_addr, prescaler;
	logic [7:0] irq_req, vec_rd_data;
	rsc_pkg::rsc_vec_rd_t vec_rd;
	rsc_pkg::rsc_clk_ctrl_t clk_ctrl;
	int n_fail = 0;
	int n_tests = 0;
	int i, n;

	always #2.5 hclk = ~hclk;

	rsc_reset_ctrl rsc_reset_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rst_pin_n(rst_pin_n), .wdog_reset(wdog_reset), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .irq_req(irq_req), .vec_rd_data(vec_rd_data),
		.vec_rd(vec_rd), .sys_reset(sys_reset), .cpu_start(cpu_start),
		.start_addr(start_addr), .trap_irq(trap_irq), .irq_active(irq_active),
		.clk_ctrl(clk_ctrl), .wdog_enable(wdog_enable), .prescaler(prescaler));

	rsc_vec_mem #(.VEC(VEC)) rsc_vec_mem_inst (.hclk(hclk), .vec_rd(vec_rd),
		.vec_rd_data(vec_rd_data));

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic clk_bad(input logic [2:0] c);
		return (!c[2] && !c[1]) || (!c[2] && !c[0]) || (!c[1] && c[0]);
	endfunction

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		check(32'(hresp), 32'h0);
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
	endtask

	task automatic wait_run;
		int k;
		k = 0;
		while (cpu_start !== 1'b1 && k < 600) begin
			@(posedge hclk);
			k++;
		end
		check(32'(k < 600), 32'h1);
		check({16'h0, start_addr}, {16'h0, VEC});
	endtask

	task automatic fault(input int b);
		int k;
		k = 0;
		while (sys_reset !== 1'b1 && k < 6) begin
			@(posedge hclk);
			k++;
		end
		check(32'(k <= 4), 32'h1);
		k = 0;
		while (sys_reset === 1'b1 && k < 400) begin
			@(posedge hclk);
			k++;
			if (k == 8) check(32'(prescaler), 32'h0);
		end
		// Pin reset ends with the pin, faults after the stretch
		if (b == rsc_pkg::CAUSE_PIN_BIT) begin
			check(32'(k <= 3), 32'h1);
		end else begin
			check(32'(k >= rsc_pkg::FAULT_MIN_CYC && k <= rsc_pkg::FAULT_MAX_CYC), 32'h1);
		end
		wait_run;
		ahb(1'b0, rsc_pkg::OFS_RST_CAUSE, 32'h0);
		check(32'(r[b]), 32'h1);
		ahb(1'b1, rsc_pkg::OFS_RST_CAUSE, 32'h1f);
	endtask

	task automatic fetch(input logic [15:0] a);
		@(posedge hclk);
		fetch_valid <= 1'b1;
		fetch_addr <= a;
		@(posedge hclk);
		fetch_valid <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial begin
		{hsel, hwrite, wdog_reset, fetch_valid, hresetn} = 5'h0;
		{haddr, hwdata} = 64'h0;
		{htrans, fetch_addr, irq_req} = 26'h0;
		hsize = 3'b010;
		rst_pin_n = 1'b1;
		r = $urandom(32'h2ba7);
		tick(2);
		hresetn <= 1'b1;
		wait_run;
		check({29'h0, clk_ctrl}, 32'h4);
		check(32'(wdog_enable), 32'h1);
		ahb(1'b0, rsc_pkg::OFS_SYS_CTRL_TWO, 32'h0);
		check(r, 32'h80);
		ahb(1'b0, rsc_pkg::OFS_WDOG_CTRL_ONE, 32'h0);
		check(r, 32'h1d);
		ahb(1'b0, 8'h40, 32'h0);
		check(r, 32'h0);
		ahb(1'b0, rsc_pkg::OFS_VECTOR, 32'h0);
		check(r, {16'h0, VEC});
		// Short pin pulse, then a long one
		rst_pin_n <= 1'b0;
		tick(100);
		rst_pin_n <= 1'b1;
		tick(5);
		check(32'(sys_reset), 32'h0);
		rst_pin_n <= 1'b0;
		n = 0;
		while (sys_reset !== 1'b1 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		check(32'(n >= rsc_pkg::PIN_LOW_CYC && n <= rsc_pkg::PIN_APPLY_MAX_CYC), 32'h1);
		rst_pin_n <= 1'b1;
		fault(rsc_pkg::CAUSE_PIN_BIT);
		// Interrupt state cleared by a watchdog reset
		ahb(1'b1, rsc_pkg::OFS_IRQ_CTRL, 32'hff01);
		@(posedge hclk);
		irq_req <= 8'($urandom) | 8'h01;
		@(posedge hclk);
		irq_req <= 8'h0;
		tick(3);
		check(32'(irq_active), 32'h1);
		@(posedge hclk);
		wdog_reset <= 1'b1;
		@(posedge hclk);
		wdog_reset <= 1'b0;
		fault(rsc_pkg::CAUSE_WDOG_BIT);
		check(32'(irq_active), 32'h0);
		ahb(1'b0, rsc_pkg::OFS_IRQ_CTRL, 32'h0);
		check(r, 32'h0);
		ahb(1'b0, rsc_pkg::OFS_IRQ_PEND, 32'h0);
		check(r, 32'h0);
		// Address traps
		ahb(1'b1, rsc_pkg::OFS_WDOG_CTRL_ONE, 32'h1c);
		for (i = 0; i < 20; i++) begin
			fetch(rsc_pkg::RAM_LO_DEF + 16'($urandom % 2048));
			fetch(16'h1000 + 16'($urandom % 16'hefff));
		end
		tick(4);
		check(32'(sys_reset), 32'h0);
		fetch(rsc_pkg::SFR_LO_DEF + 16'($urandom % 64));
		fault(rsc_pkg::CAUSE_TRAP_BIT);
		fetch(rsc_pkg::RAM_HI_DEF);
		fault(rsc_pkg::CAUSE_TRAP_BIT);
		fetch(rsc_pkg::DBR_LO_DEF);
		fault(rsc_pkg::CAUSE_TRAP_BIT);
		ahb(1'b1, rsc_pkg::OFS_WDOG_CTRL_ONE, 32'h1e);
		fetch(rsc_pkg::SFR_HI_DEF);
		n = 0;
		while (trap_irq !== 1'b1 && n < 5) begin
			@(posedge hclk);
			n++;
		end
		check(32'(n < 5), 32'h1);
		tick(4);
		check(32'(sys_reset), 32'h0);
		// Every clock control combination
		for (i = 0; i < 8; i++) begin
			ahb(1'b1, rsc_pkg::OFS_SYS_CTRL_TWO, {24'h0, i[2:0], 5'h0});
			if (clk_bad(i[2:0])) begin
				fault(rsc_pkg::CAUSE_CLK_BIT);
				check({29'h0, clk_ctrl}, 32'h4);
			end else begin
				tick(4);
				check(32'(sys_reset), 32'h0);
				check({29'h0, clk_ctrl}, {29'h0, i[2:0]});
			end
		end
		end_sim();
	end

endmodule // reset_source_controller_tb

`default_nettype wire

/* File: rsc_pkg.sv */
`default_nettype none

package rsc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing, clock period 5 ns
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned PS_PER_NS = 1000;
	localparam int unsigned FAULT_MIN_NS = 500;
	localparam int unsigned FAULT_MAX_NS = 1500;
	localparam int unsigned PIN_LOW_MIN_NS = 750;
	localparam int unsigned PIN_APPLY_MAX_NS = 1500;
	localparam int unsigned FAULT_MIN_CYC =
		(FAULT_MIN_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned FAULT_MAX_CYC = (FAULT_MAX_NS * PS_PER_NS) / CLK_PERIOD_PS;
	localparam int unsigned PIN_LOW_CYC =
		(PIN_LOW_MIN_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned PIN_APPLY_MAX_CYC = (PIN_APPLY_MAX_NS * PS_PER_NS) / CLK_PERIOD_PS;
	localparam int unsigned FAULT_DEF_CYC = 200;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] OFS_SYS_CTRL_TWO = 8'h00;
	localparam logic [7:0] OFS_WDOG_CTRL_ONE = 8'h04;
	localparam logic [7:0] OFS_RST_CAUSE = 8'h08;
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h0C;
	localparam logic [7:0] OFS_IRQ_PEND = 8'h10;
	localparam logic [7:0] OFS_PRESCALER = 8'h14;
	localparam logic [7:0] OFS_VECTOR = 8'h18;

	////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int unsigned SC_HF_EN_BIT = 7;
	localparam int unsigned SC_LF_EN_BIT = 6;
	localparam int unsigned SC_CLK_SEL_BIT = 5;
	localparam int unsigned WC_RAM_TRAP_BIT = 0;
	localparam int unsigned WC_TRAP_IRQ_BIT = 1;
	localparam int unsigned WC_TRAP_SFR_BIT = 2;
	localparam int unsigned WC_TRAP_DBR_BIT = 3;
	localparam int unsigned WC_WDOG_EN_BIT = 4;
	localparam int unsigned CAUSE_PIN_BIT = 0;
	localparam int unsigned CAUSE_TRAP_BIT = 1;
	localparam int unsigned CAUSE_WDOG_BIT = 2;
	localparam int unsigned CAUSE_CLK_BIT = 3;
	localparam int unsigned CAUSE_TRAP_IRQ_BIT = 4;
	localparam int unsigned CAUSE_W = 5;
	localparam int unsigned IRQ_MASTER_BIT = 0;
	localparam int unsigned IRQ_EN_LSB = 8;
	localparam int unsigned IRQ_MAX = 16;
	localparam logic [7:0] SYS_CTRL_TWO_RST = 8'h80;
	localparam logic [4:0] WDOG_CTRL_ONE_RST = 5'h1D;

	////////////////////////////////////////////////////////////////////////
	// Vector and region map
	localparam logic [15:0] VEC_ADDR_LO = 16'hFFFE;
	localparam logic [15:0] VEC_ADDR_HI = 16'hFFFF;
	localparam logic [15:0] SFR_LO_DEF = 16'h0000;
	localparam logic [15:0] SFR_HI_DEF = 16'h003F;
	localparam logic [15:0] RAM_LO_DEF = 16'h0040;
	localparam logic [15:0] RAM_HI_DEF = 16'h083F;
	localparam logic [15:0] DBR_LO_DEF = 16'h0F80;
	localparam logic [15:0] DBR_HI_DEF = 16'h0FFF;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		RSC_ST_HOLD = 2'b00,
		RSC_ST_LO = 2'b01,
		RSC_ST_HI = 2'b10,
		RSC_ST_RUN = 2'b11
	} rsc_vec_state_t;

	typedef struct packed {
		logic hf_osc_en;
		logic lf_osc_en;
		logic clk_sel;
	} rsc_clk_ctrl_t;

	typedef struct packed {
		logic wdog_enable;
		logic trap_dbr_en;
		logic trap_sfr_en;
		logic trap_to_irq;
		logic ram_trap_select;
	} rsc_trap_cfg_t;

	typedef struct packed {
		logic en;
		logic [15:0] addr;
	} rsc_vec_rd_t;

endpackage

`default_nettype wire

/* File: rsc_reset_ctrl.sv */
// Behaviour
// [R1] Pin, address trap, watchdog or clock failure each resets the chip.
// [R2] Fault sources are not power-on defined; only the pin reset is guaranteed.
// [R3] Pin low at power-on reaches internal reset within 24 fc periods.
// [R4] Reset clears interrupt master enable, source enables and pending latches.
// [R5] Reset clears the prescaler and leaves the watchdog enabled.
// [R6] Reset leaves CPU state and RAM; control registers take reset values.
// [R7] Outside party holds pin low at least twelve fc periods.
// [R8] On release, fetch 16-bit vector from FFFE/FFFF and start there.
// [R9] Fetch from SPECIAL_FUNCTION_REGION or data buffer traps; RAM only if select bit set.
// [R10] Address trap reset lasts about 8 to 24 fc periods.
// [R11] Option picks trap reset or trap interrupt; trapped areas selectable.
// [R12] Reset on both oscillators off, or selected clock's oscillator off.
// [R13] Clock failure reset lasts about 8 to 24 fc periods.
// [R14] Clock select bit 5 picks low-frequency clock when one.
// [R15] Clearing bit 7 stops high-frequency oscillation.
// [R16] All sources merge into one synchronous reset held until the last ends.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl #(
	parameter int unsigned FAULT_CYC = rsc_pkg::FAULT_DEF_CYC,
	parameter int unsigned IRQ_N = 8,
	parameter int unsigned PRESCALE_W = 16,
	parameter logic [15:0] SFR_LO = rsc_pkg::SFR_LO_DEF,
	parameter logic [15:0] SFR_HI = rsc_pkg::SFR_HI_DEF,
	parameter logic [15:0] RAM_LO = rsc_pkg::RAM_LO_DEF,
	parameter logic [15:0] RAM_HI = rsc_pkg::RAM_HI_DEF,
	parameter logic [15:0] DBR_LO = rsc_pkg::DBR_LO_DEF,
	parameter logic [15:0] DBR_HI = rsc_pkg::DBR_HI_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rst_pin_n,
	input wire logic wdog_reset,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic [IRQ_N-1:0] irq_req,
	input wire logic [7:0] vec_rd_data,
	output rsc_pkg::rsc_vec_rd_t vec_rd,
	output logic sys_reset,
	output logic cpu_start,
	output logic [15:0] start_addr,
	output logic trap_irq,
	output logic irq_active,
	output rsc_pkg::rsc_clk_ctrl_t clk_ctrl,
	output logic wdog_enable,
	output logic [PRESCALE_W-1:0] prescaler
);

	if (FAULT_CYC < rsc_pkg::FAULT_MIN_CYC || FAULT_CYC > rsc_pkg::FAULT_MAX_CYC) begin : g_bad_fault
		$error("rsc_reset_ctrl: FAULT_CYC outside the allowed reset span");
	end
	if (IRQ_N < 1 || IRQ_N > rsc_pkg::IRQ_MAX) begin : g_bad_irq
		$error("rsc_reset_ctrl: IRQ_N must be 1 to 16");
	end
	if (PRESCALE_W < 1 || PRESCALE_W > 32) begin : g_bad_pre
		$error("rsc_reset_ctrl: PRESCALE_W must be 1 to 32");
	end

	localparam int unsigned PIN_W = $clog2(rsc_pkg::PIN_LOW_CYC + 1);
	localparam logic [PIN_W-1:0] PIN_LOW_C = PIN_W'(rsc_pkg::PIN_LOW_CYC);

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	rsc_pkg::rsc_clk_ctrl_t sys_ctrl_two_q;
	rsc_pkg::rsc_trap_cfg_t wdog_ctrl_one_q;
	rsc_pkg::rsc_vec_state_t vec_state_q;
	logic [PIN_W-1:0] pin_low_cnt_q;
	logic sys_reset_q;
	logic pin_rst;
	logic run;
	logic trap_hit;
	logic trap_rst_ev;
	logic clk_illegal;
	logic fault_busy;
	logic clk_busy;
	logic reset_req;
	logic trap_irq_q;
	logic [rsc_pkg::CAUSE_W-1:0] cause_q;
	logic [rsc_pkg::CAUSE_W-1:0] cause_set;
	logic irq_master_enable_q;
	logic [IRQ_N-1:0] irq_source_enables_q;
	logic [IRQ_N-1:0] irq_pending_latches_q;
	logic irq_active_q;
	logic [PRESCALE_W-1:0] prescaler_q;
	logic [7:0] vec_lo_q;
	logic vec_load_q;
	logic cpu_start_q;
	logic [15:0] start_addr_q;
	logic take;
	logic wr_pend_q;
	logic [7:0] wr_ofs_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// Reset sources

	// Pin must stay low a full filter span before it applies reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_low_cnt_q <= '0;
		end else if (rst_pin_n) begin
			pin_low_cnt_q <= '0;
		end else if (pin_low_cnt_q != PIN_LOW_C) begin
			pin_low_cnt_q <= pin_low_cnt_q + 1'b1;
		end
	end
	assign pin_rst = (pin_low_cnt_q == PIN_LOW_C); // see [R3]

	assign run = (vec_state_q == rsc_pkg::RSC_ST_RUN);
	assign trap_hit = run && fetch_valid && (
		(wdog_ctrl_one_q.trap_sfr_en && in_range(fetch_addr, SFR_LO, SFR_HI)) ||
		(wdog_ctrl_one_q.trap_dbr_en && in_range(fetch_addr, DBR_LO, DBR_HI)) ||
		(wdog_ctrl_one_q.ram_trap_select && in_range(fetch_addr, RAM_LO, RAM_HI))); // see [R9]
	assign trap_rst_ev = trap_hit && !wdog_ctrl_one_q.trap_to_irq; // see [R11]

	// Selected clock or both oscillators stopped would deadlock the core
	assign clk_illegal = (!sys_ctrl_two_q.hf_osc_en && !sys_ctrl_two_q.lf_osc_en) ||
		(!sys_ctrl_two_q.hf_osc_en && !sys_ctrl_two_q.clk_sel) ||
		(!sys_ctrl_two_q.lf_osc_en && sys_ctrl_two_q.clk_sel); // see [R12]

	// Fault stretchers start empty only because flops need a reset value
	rsc_stretch #(.LEN(FAULT_CYC)) u_fault_stretch (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(trap_rst_ev || wdog_reset), // see [R10] see [R2]
		.busy(fault_busy)
	);

	rsc_stretch #(.LEN(FAULT_CYC)) u_clk_stretch (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(clk_illegal), // see [R13]
		.busy(clk_busy)
	);

	assign reset_req = pin_rst || fault_busy || clk_busy; // see [R1]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_reset_q <= 1'b1;
		end else begin
			sys_reset_q <= reset_req; // see [R16]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trap_irq_q <= 1'b0;
		end else begin
			trap_irq_q <= trap_hit && wdog_ctrl_one_q.trap_to_irq; // see [R11]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky cause record, kept across internal resets

	always_comb begin
		cause_set = '0;
		cause_set[rsc_pkg::CAUSE_PIN_BIT] = pin_rst;
		cause_set[rsc_pkg::CAUSE_TRAP_BIT] = trap_rst_ev;
		cause_set[rsc_pkg::CAUSE_WDOG_BIT] = wdog_reset;
		cause_set[rsc_pkg::CAUSE_CLK_BIT] = clk_illegal;
		cause_set[rsc_pkg::CAUSE_TRAP_IRQ_BIT] = trap_hit && wdog_ctrl_one_q.trap_to_irq;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_q <= '0;
		end else if (wr_pend_q && wr_ofs_q == rsc_pkg::OFS_RST_CAUSE) begin
			cause_q <= (cause_q & ~hwdata[rsc_pkg::CAUSE_W-1:0]) | cause_set;
		end else begin
			cause_q <= cause_q | cause_set;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_ctrl_two_q <= rsc_pkg::SYS_CTRL_TWO_RST[rsc_pkg::SC_HF_EN_BIT -: 3];
		end else if (sys_reset_q) begin
			sys_ctrl_two_q <= rsc_pkg::SYS_CTRL_TWO_RST[rsc_pkg::SC_HF_EN_BIT -: 3]; // see [R6]
		end else if (wr_pend_q && wr_ofs_q == rsc_pkg::OFS_SYS_CTRL_TWO) begin
			sys_ctrl_two_q.hf_osc_en <= hwdata[rsc_pkg::SC_HF_EN_BIT]; // see [R15]
			sys_ctrl_two_q.lf_osc_en <= hwdata[rsc_pkg::SC_LF_EN_BIT];
			sys_ctrl_two_q.clk_sel <= hwdata[rsc_pkg::SC_CLK_SEL_BIT]; // see [R14]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdog_ctrl_one_q <= rsc_pkg::WDOG_CTRL_ONE_RST;
		end else if (sys_reset_q) begin
			wdog_ctrl_one_q <= rsc_pkg::WDOG_CTRL_ONE_RST; // see [R5] see [R6]
		end else if (wr_pend_q && wr_ofs_q == rsc_pkg::OFS_WDOG_CTRL_ONE) begin
			wdog_ctrl_one_q <= hwdata[rsc_pkg::WC_WDOG_EN_BIT:rsc_pkg::WC_RAM_TRAP_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt state and timing generator

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_master_enable_q <= 1'b0;
			irq_source_enables_q <= '0;
		end else if (sys_reset_q) begin
			irq_master_enable_q <= 1'b0; // see [R4]
			irq_source_enables_q <= '0;
		end else if (wr_pend_q && wr_ofs_q == rsc_pkg::OFS_IRQ_CTRL) begin
			irq_master_enable_q <= hwdata[rsc_pkg::IRQ_MASTER_BIT];
			irq_source_enables_q <= hwdata[rsc_pkg::IRQ_EN_LSB +: IRQ_N];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_pending_latches_q <= '0;
		end else if (sys_reset_q) begin
			irq_pending_latches_q <= '0; // see [R4]
		end else if (wr_pend_q && wr_ofs_q == rsc_pkg::OFS_IRQ_PEND) begin
			irq_pending_latches_q <= (irq_pending_latches_q & ~hwdata[IRQ_N-1:0]) | irq_req;
		end else begin
			irq_pending_latches_q <= irq_pending_latches_q | irq_req;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_active_q <= 1'b0;
		end else begin
			irq_active_q <= !sys_reset_q && irq_master_enable_q &&
				|(irq_pending_latches_q & irq_source_enables_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescaler_q <= '0;
		end else if (sys_reset_q) begin
			prescaler_q <= '0; // see [R5]
		end else begin
			prescaler_q <= prescaler_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset vector fetch after release

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vec_state_q <= rsc_pkg::RSC_ST_HOLD;
		end else if (sys_reset_q) begin
			vec_state_q <= rsc_pkg::RSC_ST_HOLD;
		end else begin
			unique case (vec_state_q)
				rsc_pkg::RSC_ST_HOLD: vec_state_q <= rsc_pkg::RSC_ST_LO;
				rsc_pkg::RSC_ST_LO: vec_state_q <= rsc_pkg::RSC_ST_HI;
				rsc_pkg::RSC_ST_HI: vec_state_q <= rsc_pkg::RSC_ST_RUN;
				rsc_pkg::RSC_ST_RUN: vec_state_q <= rsc_pkg::RSC_ST_RUN;
			endcase
		end
	end

	// Read data arrives one cycle after each request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vec_lo_q <= 8'h00;
			vec_load_q <= 1'b0;
			cpu_start_q <= 1'b0;
			start_addr_q <= 16'h0000;
		end else begin
			vec_load_q <= !sys_reset_q && vec_state_q == rsc_pkg::RSC_ST_HI;
			cpu_start_q <= !sys_reset_q && vec_load_q;
			if (vec_state_q == rsc_pkg::RSC_ST_HI) begin
				vec_lo_q <= vec_rd_data;
			end
			if (vec_load_q) begin
				start_addr_q <= {vec_rd_data, vec_lo_q}; // see [R8]
			end
		end
	end

	assign vec_rd.en = (vec_state_q == rsc_pkg::RSC_ST_LO) || (vec_state_q == rsc_pkg::RSC_ST_HI);
	assign vec_rd.addr = (vec_state_q == rsc_pkg::RSC_ST_HI) ? rsc_pkg::VEC_ADDR_HI :
		rsc_pkg::VEC_ADDR_LO; // see [R8]

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	assign take = hsel && hready && htrans[1];

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr[7:0])
			rsc_pkg::OFS_SYS_CTRL_TWO: rd_mux[rsc_pkg::SC_HF_EN_BIT -: 3] = sys_ctrl_two_q;
			rsc_pkg::OFS_WDOG_CTRL_ONE: rd_mux[rsc_pkg::WC_WDOG_EN_BIT:0] = wdog_ctrl_one_q;
			rsc_pkg::OFS_RST_CAUSE: rd_mux[rsc_pkg::CAUSE_W-1:0] = cause_q;
			rsc_pkg::OFS_IRQ_CTRL: begin
				rd_mux[rsc_pkg::IRQ_MASTER_BIT] = irq_master_enable_q;
				rd_mux[rsc_pkg::IRQ_EN_LSB +: IRQ_N] = irq_source_enables_q;
			end
			rsc_pkg::OFS_IRQ_PEND: rd_mux[IRQ_N-1:0] = irq_pending_latches_q;
			rsc_pkg::OFS_PRESCALER: rd_mux[PRESCALE_W-1:0] = prescaler_q;
			rsc_pkg::OFS_VECTOR: rd_mux[15:0] = start_addr_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= take && hwrite;
			if (take) begin
				wr_ofs_q <= haddr[7:0];
			end
			hrdata_q <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	assign sys_reset = sys_reset_q;
	assign cpu_start = cpu_start_q;
	assign start_addr = start_addr_q;
	assign trap_irq = trap_irq_q;
	assign irq_active = irq_active_q;
	assign clk_ctrl = sys_ctrl_two_q;
	assign wdog_enable = wdog_ctrl_one_q.wdog_enable;
	assign prescaler = prescaler_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_ANY_SOURCE: assert property ((pin_rst || fault_busy || clk_busy) |=> sys_reset_q) // see [R1]
		else $error("active source did not hold reset");
	AST_PIN_APPLY: assert property ((!rst_pin_n && pin_low_cnt_q == PIN_LOW_C) |=> sys_reset_q) // see [R3]
		else $error("pin reset not applied in time");
	AST_TRAP_RESET: assert property (trap_rst_ev |=> ##1 sys_reset_q [*8]) // see [R10]
		else $error("trap reset too short");
	AST_TRAP_IRQ: assert property ((trap_hit && wdog_ctrl_one_q.trap_to_irq && !wdog_reset)
		|=> trap_irq && !fault_busy) // see [R11]
		else $error("trap in interrupt mode misrouted");
	AST_CLK_FAIL: assert property (clk_illegal |=> ##1 sys_reset_q [*8]) // see [R12]
		else $error("clock failure reset missing");
	AST_IRQ_CLEAR: assert property (sys_reset_q |=> !irq_master_enable_q &&
		irq_source_enables_q == '0 && irq_pending_latches_q == '0) // see [R4]
		else $error("interrupt state not cleared");
	AST_PRESCALE: assert property (sys_reset_q |=> prescaler_q == '0 && wdog_enable) // see [R5]
		else $error("prescaler or watchdog not reset");
	AST_CTRL_RESET: assert property (sys_reset_q |=> clk_ctrl.hf_osc_en && !clk_ctrl.clk_sel) // see [R6]
		else $error("clock control not at reset value");
	AST_VECTOR: assert property (($fell(sys_reset_q) ##1 !sys_reset_q [*3])
		|=> cpu_start && start_addr[15:8] == $past(vec_rd_data)) // see [R8]
		else $error("vector start wrong");

	COV_TRAP_RESET: cover property (trap_rst_ev ##1 sys_reset_q);
	COV_TRAP_IRQ: cover property (trap_irq);
	COV_CLK_FAIL: cover property (clk_illegal ##1 sys_reset_q);
	COV_START: cover property (cpu_start);

endmodule // rsc_reset_ctrl

`default_nettype wire

/* File: rsc_stretch.sv */
`timescale 1ns/1ps
`default_nettype none

module rsc_stretch #(
	parameter int unsigned LEN = 200
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	output logic busy
);

	localparam int unsigned CW = $clog2(LEN + 1);
	localparam logic [CW-1:0] LEN_C = CW'(LEN);

	if (LEN < 1) begin : g_bad_len
		$error("rsc_stretch: LEN must be at least one");
	end

	logic [CW-1:0] cnt_q;

	// Reload on every event so the longest request wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= LEN_C;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign busy = (cnt_q != '0);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_STRETCH_RUN: assert property (load |=> busy [*8]) // see [R13]
		else $error("stretch ended too early");

endmodule // rsc_stretch

`default_nettype wire

/* File: rsc_vec_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module rsc_vec_mem #(
	parameter logic [15:0] VEC = 16'h1234
) (
	input wire logic hclk,
	input wire rsc_pkg::rsc_vec_rd_t vec_rd,
	output logic [7:0] vec_rd_data
);

	initial vec_rd_data = 8'h5a;

	// Idle bus shows the inverse of the last byte
	always @(posedge hclk) begin
		if (vec_rd.en && vec_rd.addr == rsc_pkg::VEC_ADDR_HI) begin
			vec_rd_data <= VEC[15:8];
		end else if (vec_rd.en && vec_rd.addr == rsc_pkg::VEC_ADDR_LO) begin
			vec_rd_data <= VEC[7:0];
		end else begin
			vec_rd_data <= ~vec_rd_data;
		end
	end

endmodule // rsc_vec_mem

`default_nettype wire
